// *** core/dbrw_ctl.sv ***
/*
  controller end: makes the link clock by division, issues one
  command per request keeping bank spacing, drives write bursts.
  assumes the device end returns read data at rl.
*/
`timescale 1ns/1ps
`default_nettype none
module dbrw_ctl
  import dbrw_pkg::*;
#(
  parameter int DW = 16,
  parameter int AW = 13,
  parameter int AL = 0,
  parameter int RAS_CYC = 4,
  parameter int RP_CYC = 2,
  parameter int RC_CYC = 6
)(
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic REQ_VALID_IN,
  output logic REQ_READY_OUT,
  input wire logic [2:0] REQ_CMD_IN,
  input wire logic [2:0] REQ_BANK_IN,
  input wire logic [AW-1:0] REQ_ADDR_IN,
  input wire logic [DW-1:0] WR_DATA_IN,
  output logic [DW-1:0] RD_DATA_OUT,
  output logic RD_VALID_OUT,
  dbrw_if.ctrl LNK
);
  localparam int TW = 8;
  logic [3:0] div_r;
  logic ck_r;
  wire tick = div_r == 4'(CK_DIV/2 - 1);
  wire rise = tick && !ck_r;

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
    if (!RST_N_IN)
    begin
      div_r <= '0;
      ck_r <= 1'b0;
    end
    else
    begin
      div_r <= tick ? '0 : div_r + 1'b1;
      if (tick)
        ck_r <= !ck_r;
    end

  // per-bank spacing counters and a shared ccd counter, in link cycles
  logic [TW-1:0] pre_ok_r [8];
  logic [TW-1:0] act_ok_r [8];
  logic [TW-1:0] ccd_r;
  wire [TW-1:0] pre_w = pre_ok_r[REQ_BANK_IN];
  wire [TW-1:0] act_w = act_ok_r[REQ_BANK_IN];
  wire is_pre = REQ_CMD_IN == CMD_PRE;
  wire is_act = REQ_CMD_IN == CMD_ACT;
  wire is_col = REQ_CMD_IN == CMD_RD || REQ_CMD_IN == CMD_WR;
  wire ok = (!is_pre || pre_w == '0) && (!is_act || act_w == '0) &&
    (!is_col || ccd_r == '0);
  assign REQ_READY_OUT = rise && ok;
  wire go = REQ_VALID_IN && REQ_READY_OUT;

  genvar b;
  generate
    for (b = 0; b < 8; b++)
    begin : g_bank
      wire hit = go && REQ_BANK_IN == 3'(b);
      always_ff @(posedge CLK_IN or negedge RST_N_IN)
        if (!RST_N_IN)
        begin
          pre_ok_r[b] <= '0;
          act_ok_r[b] <= '0;
        end
        else if (hit && is_act)
        begin
          pre_ok_r[b] <= TW'(RAS_CYC);
          act_ok_r[b] <= TW'(RC_CYC);
        end
        else if (hit && REQ_CMD_IN == CMD_RD)
        begin
          if (pre_ok_r[b] < TW'(AL + RTP_CYC))
            pre_ok_r[b] <= TW'(AL + RTP_CYC);
        end
        else if (hit && is_pre)
        begin
          if (act_ok_r[b] < TW'(RP_CYC))
            act_ok_r[b] <= TW'(RP_CYC);
        end
        else if (rise)
        begin
          if (pre_ok_r[b] != '0)
            pre_ok_r[b] <= pre_ok_r[b] - 1'b1;
          if (act_ok_r[b] != '0)
            act_ok_r[b] <= act_ok_r[b] - 1'b1;
        end
    end
  endgenerate

  logic [2:0] cmd_r, ba_r;
  logic [AW-1:0] ad_r;
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
    if (!RST_N_IN)
    begin
      cmd_r <= CMD_NOP;
      ba_r <= '0;
      ad_r <= '0;
      ccd_r <= '0;
    end
    else if (go)
    begin
      cmd_r <= REQ_CMD_IN;
      ba_r <= REQ_BANK_IN;
      ad_r <= REQ_ADDR_IN;
      if (is_col)
        ccd_r <= TW'(CCD_NCK);
    end
    else if (rise)
    begin
      cmd_r <= CMD_NOP;
      if (ccd_r != '0)
        ccd_r <= ccd_r - 1'b1;
    end

  // write data: strobe toggles each half link cycle with held data
  logic [3:0] wbeat_r;
  logic dqs_r, woe_n_r;
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
    if (!RST_N_IN)
    begin
      wbeat_r <= '0;
      dqs_r <= 1'b0;
      woe_n_r <= 1'b1;
    end
    else if (go && REQ_CMD_IN == CMD_WR)
    begin
      wbeat_r <= REQ_ADDR_IN[BURST_BIT] ? 4'h8 : 4'h4;
      woe_n_r <= 1'b0;
    end
    else if (tick && wbeat_r != '0)
    begin
      dqs_r <= !dqs_r;
      wbeat_r <= wbeat_r - 1'b1;
    end
    else if (tick)
      woe_n_r <= 1'b1;

  logic [DW-1:0] rd_r, dq_s1_r, dq_s2_r;
  logic v_r, oe_s1_r, oe_s2_r, oe_s3_r;
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
    if (!RST_N_IN)
    begin
      dq_s1_r <= '0;
      dq_s2_r <= '0;
      rd_r <= '0;
      v_r <= 1'b0;
      oe_s1_r <= 1'b0;
      oe_s2_r <= 1'b0;
      oe_s3_r <= 1'b0;
    end
    else
    begin
      dq_s1_r <= LNK.dq;
      dq_s2_r <= dq_s1_r;
      oe_s1_r <= LNK.dqs;
      oe_s2_r <= oe_s1_r;
      oe_s3_r <= oe_s2_r;
      // a returned beat is a strobe edge while we are not writing
      v_r <= woe_n_r && (oe_s2_r != oe_s3_r);
      rd_r <= dq_s2_r;
    end

  assign LNK.ck = ck_r;
  assign LNK.cmd = cmd_r;
  assign LNK.ba = ba_r;
  assign LNK.addr = ad_r;
  assign LNK.ap = 2'h0;
  assign LNK.c_dqs_o = dqs_r;
  assign LNK.c_dqs_oe_n = woe_n_r;
  assign LNK.c_dq_o = WR_DATA_IN;
  assign LNK.c_dq_oe_n = woe_n_r;
  assign RD_DATA_OUT = rd_r;
  assign RD_VALID_OUT = v_r;
endmodule
`default_nettype wire

// *** core/dbrw_dev.sv ***
/*
  memory device end: samples the link clock, decodes commands on its
  rising edges, stores write bursts and drives read bursts.
  assumes the controller keeps its own spacing rules.
*/
// Behaviour
// - A12 high under otf or fixed gives eight
// - A12 low chops to four, ccd four
// - A12 never part of column address
// - otf works with or without auto precharge
// - precharge waits al plus rtp after read
// - rtp at least four clocks and 7.5 ns
// - precharge also honours activate-to-precharge time
// - reactivate after rp and rc both met
// - strobe at rl minus one, data at rl
// - release at rl plus four or two
// - read timing only valid with dll locked
// - controller resets after general timing violation; neither end here detects a violation or resets on one
// - setup/hold violation corrupts only addressed word
// - strobe violations corrupt only location, no hang
`timescale 1ns/1ps
`default_nettype none
module dbrw_dev
  import dbrw_pkg::*;
#(
  parameter int DW = 16,
  parameter int AW = 13,
  parameter int CW = 10,
  parameter int AL = 0,
  parameter int CL = 5,
  parameter int CWL = 5,
  parameter logic [1:0] MR_BL = BL_OTF
)(
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic DLL_LOCK_IN,
  output logic RD_ACTIVE_OUT,
  output logic WR_ACTIVE_OUT,
  dbrw_if.dev LNK
);
  localparam int RL = AL + CL;
  localparam int WL = AL + CWL;
  localparam int DEPTH = 1 << (CW + 3);
  localparam int TW = 8;

  logic [DW-1:0] mem [DEPTH];
  logic ck_s1_r, ck_s2_r, ck_s3_r;
  logic [2:0] cmd_s1_r, cmd_s2_r;
  logic [2:0] ba_s1_r, ba_s2_r;
  logic [AW-1:0] ad_s1_r, ad_s2_r;
  logic dq_edge_s1_r, dq_edge_s2_r, dqs_s3_r;
  logic [DW-1:0] dq_s1_r, dq_s2_r;
  logic dll_s1_r, dll_s2_r;

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
    if (!RST_N_IN)
    begin
      ck_s1_r <= 1'b0;
      ck_s2_r <= 1'b0;
      ck_s3_r <= 1'b0;
      cmd_s1_r <= CMD_NOP;
      cmd_s2_r <= CMD_NOP;
      ba_s1_r <= '0;
      ba_s2_r <= '0;
      ad_s1_r <= '0;
      ad_s2_r <= '0;
      dq_edge_s1_r <= 1'b0;
      dq_edge_s2_r <= 1'b0;
      dqs_s3_r <= 1'b0;
      dq_s1_r <= '0;
      dq_s2_r <= '0;
      dll_s1_r <= 1'b0;
      dll_s2_r <= 1'b0;
    end
    else
    begin
      ck_s1_r <= LNK.ck;
      ck_s2_r <= ck_s1_r;
      ck_s3_r <= ck_s2_r;
      cmd_s1_r <= LNK.cmd;
      cmd_s2_r <= cmd_s1_r;
      ba_s1_r <= LNK.ba;
      ba_s2_r <= ba_s1_r;
      ad_s1_r <= LNK.addr;
      ad_s2_r <= ad_s1_r;
      dq_edge_s1_r <= LNK.dqs;
      dq_edge_s2_r <= dq_edge_s1_r;
      dqs_s3_r <= dq_edge_s2_r;
      dq_s1_r <= LNK.dq;
      dq_s2_r <= dq_s1_r;
      dll_s1_r <= DLL_LOCK_IN;
      dll_s2_r <= dll_s1_r;
    end

  wire ck_rise = ck_s2_r && !ck_s3_r;
  wire dqs_edge = dq_edge_s2_r != dqs_s3_r;
  // A12 only picks the burst; column is the low CW bits
  wire burst8 = (MR_BL == BL_FIXED8) ||
    ((MR_BL == BL_OTF) && ad_s2_r[BURST_BIT]);
  // auto precharge bit plays no part in burst choice
  wire [CW-1:0] col = ad_s2_r[CW-1:0];
  wire rd_cmd = ck_rise && (cmd_s2_r == CMD_RD);
  wire wr_cmd = ck_rise && (cmd_s2_r == CMD_WR);

  // read: a delay line of link cycles, so reads at ccd spacing overlap
  localparam int EW = CW + 4;
  logic [RL-1:0] rd_v_r;
  logic [RL*EW-1:0] rd_line_r;
  logic [3:0] rd_len_r;
  logic [3:0] rd_beat_r;
  logic rd_on_r;
  logic [2:0] rd_ba_r;
  logic [CW-1:0] rd_col_r;
  logic [DW-1:0] dq_out_r;
  logic dqs_out_r, dqs_oe_n_r, dq_oe_n_r;
  wire rd_take = rd_cmd && dll_s2_r;
  wire rd_pre = rd_v_r[RL-2];
  wire rd_start = rd_v_r[RL-1];
  wire [EW-1:0] rd_head = rd_line_r[RL*EW-1 -: EW];
  wire rd_last = rd_on_r && rd_len_r == 4'h1;
  // a new burst at the release edge keeps the bus driven
  wire rd_keep = rd_start || (rd_on_r && !rd_last);
  // one beat per half link cycle, when the strobe lags the link clock
  wire rd_step = ck_s2_r == ck_s3_r && ck_s2_r != dqs_out_r;
  wire [3:0] rd_half = rd_head[EW-1] ? 4'(BL8_HALF) : 4'(BC4_HALF);
  wire [CW+2:0] rd_idx = {rd_ba_r, rd_col_r} + (CW+3)'(rd_beat_r);

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
    if (!RST_N_IN)
    begin
      rd_v_r <= '0;
      rd_line_r <= '0;
      rd_len_r <= '0;
      rd_beat_r <= '0;
      rd_on_r <= 1'b0;
      rd_ba_r <= '0;
      rd_col_r <= '0;
      dq_out_r <= '0;
      dqs_out_r <= 1'b0;
      dqs_oe_n_r <= 1'b1;
      dq_oe_n_r <= 1'b1;
    end
    else if (ck_rise)
    begin
      rd_v_r <= {rd_v_r[RL-2:0], rd_take};
      rd_line_r <= {rd_line_r[(RL-1)*EW-1:0], burst8, ba_s2_r, col};
      rd_on_r <= rd_keep;
      rd_len_r <= rd_start ? rd_half : rd_len_r - 1'b1;
      dq_oe_n_r <= !rd_keep;
      dqs_oe_n_r <= !(rd_keep || rd_pre);
      if (rd_start)
      begin
        rd_ba_r <= rd_head[EW-2 -: 3];
        rd_col_r <= rd_head[CW-1:0];
        rd_beat_r <= '0;
      end
    end
    else if (rd_on_r && rd_step)
    begin
      dq_out_r <= mem[rd_idx];
      dqs_out_r <= ck_s2_r;
      rd_beat_r <= rd_beat_r + 1'b1;
    end

  // write: capture on each strobe edge; bad edges only touch this burst
  logic [TW-1:0] wr_cnt_r;
  logic [3:0] wr_beat_r, wr_max_r;
  logic wr_on_r;
  logic [2:0] wr_ba_r;
  logic [CW-1:0] wr_col_r;
  wire [CW+2:0] wr_idx = {wr_ba_r, wr_col_r} + (CW+3)'(wr_beat_r);

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
    if (!RST_N_IN)
    begin
      wr_cnt_r <= '0;
      wr_beat_r <= '0;
      wr_max_r <= '0;
      wr_on_r <= 1'b0;
      wr_ba_r <= '0;
      wr_col_r <= '0;
    end
    else if (wr_cmd)
    begin
      wr_on_r <= 1'b1;
      wr_beat_r <= '0;
      wr_max_r <= burst8 ? 4'h8 : 4'h4;
      wr_cnt_r <= TW'(WL + BL8_HALF + 2);
      wr_ba_r <= ba_s2_r;
      wr_col_r <= col;
    end
    else if (wr_on_r)
    begin
      if (ck_rise)
        wr_cnt_r <= wr_cnt_r - 1'b1;
      // window timeout guarantees exit even if strobes are missing
      if ((ck_rise && wr_cnt_r == '0) || wr_beat_r == wr_max_r)
        wr_on_r <= 1'b0;
      else if (dqs_edge)
        wr_beat_r <= wr_beat_r + 1'b1;
    end

  always_ff @(posedge CLK_IN)
    if (wr_on_r && dqs_edge && wr_beat_r != wr_max_r)
      mem[wr_idx] <= dq_s2_r;

  assign LNK.d_dqs_o = dqs_out_r;
  assign LNK.d_dqs_oe_n = dqs_oe_n_r;
  assign LNK.d_dq_o = dq_out_r;
  assign LNK.d_dq_oe_n = dq_oe_n_r;
  assign RD_ACTIVE_OUT = rd_on_r;
  assign WR_ACTIVE_OUT = wr_on_r;
endmodule
`default_nettype wire

// *** core/dbrw_if.sv ***
/*
  link between controller and device: link clock, command, address,
  bidirectional strobe and data resolved from the enables.
  assumes the bench instantiates it once and joins both ends.
*/
`timescale 1ns/1ps
`default_nettype none
interface dbrw_if #(parameter int DW = 16, parameter int AW = 13);
  logic ck;
  logic [2:0] cmd;
  logic [2:0] ba;
  logic [AW-1:0] addr;
  logic [1:0] ap;
  logic c_dqs_o;
  logic c_dqs_oe_n;
  logic [DW-1:0] c_dq_o;
  logic c_dq_oe_n;
  logic d_dqs_o;
  logic d_dqs_oe_n;
  logic [DW-1:0] d_dq_o;
  logic d_dq_oe_n;
  wire dqs = !c_dqs_oe_n ? c_dqs_o : (!d_dqs_oe_n ? d_dqs_o : 1'b0);
  wire [DW-1:0] dq = !c_dq_oe_n ? c_dq_o : (!d_dq_oe_n ? d_dq_o : '0);
  modport ctrl (output ck, cmd, ba, addr, ap, c_dqs_o, c_dqs_oe_n,
    c_dq_o, c_dq_oe_n, input dqs, dq);
  modport dev (input ck, cmd, ba, addr, ap, dqs, dq,
    output d_dqs_o, d_dqs_oe_n, d_dq_o, d_dq_oe_n);
endinterface
`default_nettype wire

// *** core/dbrw_pkg.sv ***
/*
  shared constants for the burst read/write link between a memory
  controller end and a memory device end.
  assumes both ends run on the same 100 MHz system clock.
*/
package dbrw_pkg;
  localparam int CLK_PERIOD_PS = 10000;
  localparam int RTP_MIN_PS = 7500;
  localparam int RTP_MIN_NCK = 4;
  localparam int RTP_PS_CYC = (RTP_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RTP_CYC = (RTP_MIN_NCK > RTP_PS_CYC) ? RTP_MIN_NCK
                                                       : RTP_PS_CYC;
  localparam int CCD_NCK = 4;
  localparam int BL8_HALF = 4;
  localparam int BC4_HALF = 2;
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  localparam logic [2:0] CMD_NOP = 3'h0;
  localparam logic [2:0] CMD_ACT = 3'h1;
  localparam logic [2:0] CMD_RD = 3'h2;
  localparam logic [2:0] CMD_WR = 3'h3;
  localparam logic [2:0] CMD_PRE = 3'h4;
  localparam int BURST_BIT = 12;
  localparam int CK_DIV = 8;
endpackage

// *** tb/dbrw_props.sv ***
/*
  checker on the link: command spacing and read drive windows.
  assumes ck is CLK_IN/8, one bank in use at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module dbrw_props
  import dbrw_pkg::*;
#(
  parameter int AL = 0,
  parameter int RAS_CYC = 4,
  parameter int RP_CYC = 2,
  parameter int RC_CYC = 6
)(
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic DLL_LOCK_IN,
  input wire logic ck,
  input wire logic [2:0] cmd,
  input wire logic [12:0] addr,
  input wire logic d_dqs_oe_n,
  input wire logic d_dq_oe_n
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  logic ck_r;
  logic [4:0] col_r, rd_r, act_r, pre_r;
  wire rise = ck && !ck_r;
  wire col = rise && (cmd == CMD_RD || cmd == CMD_WR);
  wire rdc = rise && cmd == CMD_RD;
  wire rd = rdc && DLL_LOCK_IN;
  wire pre = rise && cmd == CMD_PRE;
  wire act = rise && cmd == CMD_ACT;
  wire bl8 = addr[BURST_BIT];
  // ages in link cycles saturate, so a fresh reset never reads as too close
  function automatic logic [4:0] age(logic [4:0] c, logic hit);
    return hit ? 5'h01 : c + {4'h0, rise && c != 5'h1F};
  endfunction
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
    if (!RST_N_IN)
    begin
      ck_r <= 1'b0;
      {col_r, rd_r, act_r, pre_r} <= '1;
    end
    else
    begin
      ck_r <= ck;
      col_r <= age(col_r, col);
      rd_r <= age(rd_r, rdc);
      act_r <= age(act_r, act);
      pre_r <= age(pre_r, pre);
    end
  a_ccd_spacing: assert property (col |-> col_r >= 5'(CCD_NCK))
    else $error("column commands too close");
  a_rd_to_pre: assert property (pre |-> rd_r >= 5'(AL + RTP_CYC))
    else $error("precharge too soon after read");
  a_act_to_pre: assert property (pre |-> act_r >= 5'(RAS_CYC))
    else $error("precharge too soon after activate");
  a_act_again: assert property (act
    |-> pre_r >= 5'(RP_CYC) && act_r >= 5'(RC_CYC))
    else $error("activate too soon");
  a_strobe_on: assert property (rd |-> ##[31:40] $fell(d_dqs_oe_n))
    else $error("read strobe drive late or early");
  a_data_on: assert property (rd
    |-> ##[39:48] $fell(d_dq_oe_n))
    else $error("read data drive late or early");
  a_bl8_off: assert property (rd && bl8
    |-> ##[71:80] $rose(d_dq_oe_n))
    else $error("eight beat release misplaced");
  a_bc4_off: assert property (rd && !bl8
    |-> ##[55:64] $rose(d_dqs_oe_n))
    else $error("chopped release misplaced");
  a_unlocked_quiet: assert property (rdc && !DLL_LOCK_IN
    |-> not (##[1:80] !d_dqs_oe_n))
    else $error("read driven while unlocked");
endmodule
`default_nettype wire

// *** tb/test_ddr3_burst_read_write_timing.sv ***
/*
  bench joining controller and device end; drives the user side.
  assumes 100 MHz clock and a link clock of one eighth of it.
*/
`timescale 1ns/1ps
`default_nettype none
module test_ddr3_burst_read_write_timing;
  import dbrw_pkg::*;
  logic clk, rst_n, dll, valid, ready, rvalid, rd_act, wr_act;
  int rbeats = 0;
  logic [2:0] rcmd, bank;
  logic [12:0] addr;
  logic [15:0] wdata, rdata;
  logic [15:0] exp_dq = 16'hA5C3;
  logic dqs_r = 1'b0;
  int err_total = 0;
  int check_count = 0;
  int beats = 0;
  dbrw_if dbrw_if_i ();
  dbrw_ctl dbrw_ctl_i (
    .CLK_IN(clk), .RST_N_IN(rst_n), .REQ_VALID_IN(valid),
    .REQ_READY_OUT(ready), .REQ_CMD_IN(rcmd), .REQ_BANK_IN(bank),
    .REQ_ADDR_IN(addr), .WR_DATA_IN(wdata), .RD_DATA_OUT(rdata),
    .RD_VALID_OUT(rvalid), .LNK(dbrw_if_i.ctrl));
  dbrw_dev dbrw_dev_i (.CLK_IN(clk), .RST_N_IN(rst_n), .DLL_LOCK_IN(dll),
    .RD_ACTIVE_OUT(rd_act), .WR_ACTIVE_OUT(wr_act), .LNK(dbrw_if_i.dev));
  dbrw_props dbrw_props_i (
    .CLK_IN(clk), .RST_N_IN(rst_n), .DLL_LOCK_IN(dll),
    .ck(dbrw_if_i.ck), .cmd(dbrw_if_i.cmd), .addr(dbrw_if_i.addr),
    .d_dqs_oe_n(dbrw_if_i.d_dqs_oe_n), .d_dq_oe_n(dbrw_if_i.d_dq_oe_n));
  task automatic chk(input bit ok, input string m);
    check_count++;
    if (!ok)
      begin
        err_total++;
        $display("MISMATCH %0t %s", $time, m);
      end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // a beat is one strobe edge while the device drives data
  always @(posedge clk)
  begin
    dqs_r <= dbrw_if_i.dqs;
    if (dbrw_if_i.d_dq_oe_n === 1'b0 && dbrw_if_i.dqs !== dqs_r)
    begin
      beats++;
      chk(dbrw_if_i.dq === exp_dq, "read beat data");
    end
    if (rvalid === 1'b1)
    begin
      rbeats++;
      chk(rdata === exp_dq, "returned read data");
    end
  end
  task automatic req(input logic [2:0] c, input logic [12:0] a);
    int n;
    n = 0;
    @(posedge clk) #1;
    valid = 1'b1;
    rcmd = c;
    addr = a;
    @(negedge clk);
    while (ready !== 1'b1 && n < 400)
    begin
      @(negedge clk);
      n++;
    end
    chk(n < 400, "request not taken");
    @(posedge clk) #1;
    valid = 1'b0;
  endtask
  // the wait covers rl plus four link cycles and the sync delay
  task automatic rd_wait(input int n, input string m);
    repeat (110) @(posedge clk);
    #1;
    chk(beats == n, m);
    chk(rbeats == n, "controller beat count");
    chk(rd_act === 1'b0 && wr_act === 1'b0, "burst left active");
    beats = 0;
    rbeats = 0;
  endtask
  task automatic test_bl8();
    req(CMD_ACT, 13'h0040);
    req(CMD_WR, 13'h1010);
    repeat (8) @(posedge clk);
    #1;
    chk(wr_act === 1'b1, "write burst not taken");
    repeat (112) @(posedge clk);
    req(CMD_RD, 13'h1010);
    rd_wait(8, "eight beat count");
    $display("bl8 test done");
  endtask
  task automatic test_bc4();
    req(CMD_RD, 13'h0010);
    rd_wait(4, "chopped beat count");
    req(CMD_RD, 13'h0010);
    req(CMD_RD, 13'h0014);
    rd_wait(8, "back to back chops");
    $display("bc4 test done");
  endtask
  task automatic test_unlocked();
    dll = 1'b0;
    req(CMD_RD, 13'h1010);
    rd_wait(0, "unlocked read driven");
    dll = 1'b1;
    $display("unlocked test done");
  endtask
  task automatic test_precharge();
    req(CMD_RD, 13'h1010);
    req(CMD_PRE, 13'h0000);
    req(CMD_ACT, 13'h0040);
    rd_wait(8, "read before precharge");
    req(CMD_RD, 13'h1010);
    rd_wait(8, "read after reopen");
    $display("precharge test done");
  endtask
  // a mid-run reset must leave the device usable, stored data intact
  task automatic test_reset();
    rst_n = 1'b0;
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    chk(rd_act === 1'b0 && wr_act === 1'b0, "busy after reset");
    req(CMD_RD, 13'h1010);
    rd_wait(8, "read after reset");
    $display("reset test done");
  endtask
  initial
  begin
    #100000;
    err_total++;
    end_of_test();
  end
  initial
  begin
    rst_n = 1'b0;
    dll = 1'b1;
    valid = 1'b0;
    rcmd = CMD_NOP;
    bank = 3'h0;
    addr = 13'h0000;
    wdata = 16'hA5C3;
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    test_bl8();
    test_bc4();
    test_unlocked();
    test_precharge();
    test_reset();
    end_of_test();
  end
endmodule
`default_nettype wire
